// >>> tlbinv_pkg.sv
// Purpose: constants and types for the hypervisor and second-stage
//          tlb invalidation block
// Assumes: one clock, synchronous active-low reset
// Notes:   opcode and register codes are local to this block
//
// Notes on behaviour
// R1: hyp va-all-asid from ns/s queue hits ns hyp
// R2: leaf flag limits invalidation to leaf entries
// R3: host bit one: hit host-mode entries any asid
// R4: host bit zero: hit plain hyp entries
// R5: software keeps host bit known when queuing
// R6: no hyp support: hyp commands are illegal
// R7: ns and s queues give identical effect
// R8: realm queue va-all-asid hits realm hyp entries
// R9: hyp by-asid hits non-global host-mode entries
// R10: realm queue by-asid hits realm host-mode entries
// R11: secure hyp commands act on secure hyp entries
// R12: secure hyp illegal off secure queue, unsupported
// R13: second stage ipa matches vmid and ipa
// R14: no second stage: ipa, vmid commands illegal
// R15: ipa low twelve bits zero, high bits range
// R16: ipa hits second-stage-only entries, not combined
// R17: entries tagged va-based or ipa-based
// R18: realm queue ipa hits realm second stage
// R19: vmid all-stages hits ns el1, realm el1
// R20: secure ipa selector picks secure or ns space
// R21: secure stage two commands illegal off secure queue
// R22: secure vmid hits secure regime entries
// R23: hyp all hits every hyp entry, tagged or not
// R24: illegal command performs no invalidation
package tlbinv_pkg;

  localparam int NENT   = 8;
  localparam int IDXW   = 3;
  localparam int AW     = 48;
  localparam int PG_LSB = 12;
  localparam int PGW    = AW - PG_LSB;
  // input_address_size of the second stage
  localparam int IN_ADDR_W = 44;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CAPS = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;

  localparam int CTRL_NS_HOST  = 0;
  localparam int CTRL_SEC_HOST = 1;
  localparam int CTRL_RLM_HOST = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;

  localparam int STAT_VLD_LSB = 0;
  localparam int STAT_ERR_LSB = 8;
  localparam int STAT_OP_LSB  = 16;

  typedef enum logic [3:0] {
    TLBINV_HYP_ALL       = 4'b0000,
    TLBINV_HYP_VA        = 4'b0001,
    TLBINV_HYP_VAA       = 4'b0010,
    TLBINV_HYP_ASID      = 4'b0011,
    TLBINV_SEC_HYP_ALL   = 4'b0100,
    TLBINV_SEC_HYP_VA    = 4'b0101,
    TLBINV_SEC_HYP_VAA   = 4'b0110,
    TLBINV_SEC_HYP_ASID  = 4'b0111,
    TLBINV_S2_IPA        = 4'b1000,
    TLBINV_S12_VMID      = 4'b1001,
    TLBINV_SEC_S2_IPA    = 4'b1010,
    TLBINV_SEC_S12_VMID  = 4'b1011
  } tlbinv_op_t;

  typedef enum logic [1:0] {
    TLBINV_Q_NS    = 2'b00,
    TLBINV_Q_SEC   = 2'b01,
    TLBINV_Q_REALM = 2'b10
  } tlbinv_queue_t;

  typedef enum logic [1:0] {
    TLBINV_W_NS    = 2'b00,
    TLBINV_W_SEC   = 2'b01,
    TLBINV_W_REALM = 2'b10
  } tlbinv_world_t;

  typedef enum logic [1:0] {
    TLBINV_L_EL1  = 2'b00,
    TLBINV_L_HYP  = 2'b01,
    TLBINV_L_HOST = 2'b10
  } tlbinv_level_t;

  typedef enum logic [1:0] {
    TLBINV_ST_S1  = 2'b00,
    TLBINV_ST_S2  = 2'b01,
    TLBINV_ST_S12 = 2'b10
  } tlbinv_stage_t;

  typedef struct packed {
    logic          valid;
    tlbinv_world_t world;
    tlbinv_level_t level;
    tlbinv_stage_t stage;
    logic          glob;
    logic          leaf;
    logic          ipa_ns;
    logic [15:0]   asid;
    logic [15:0]   vmid;
    logic [PGW-1:0] page;
  } tlbinv_ent_t;

  typedef struct packed {
    logic          valid;
    logic [3:0]    op;
    tlbinv_queue_t queue;
    logic [15:0]   asid;
    logic [15:0]   vmid;
    logic [AW-1:0] addr;
    logic          leaf;
    logic          ipa_space_select;
  } tlbinv_cmd_t;

  typedef struct packed {
    logic hyp;
    logic s2;
    logic sec_hyp;
    logic sec_s2;
  } tlbinv_caps_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } tlbinv_bus_t;

  typedef struct packed {
    logic            valid;
    logic [IDXW-1:0] idx;
    tlbinv_ent_t     ent;
  } tlbinv_fill_t;

endpackage

// >>> tlbinv_top.sv
// Purpose: tlb store with hypervisor and second-stage invalidation
// Assumes: one command per cycle, answer one cycle later
// Notes:   fill port inserts entries; a fill beats a same-cycle hit
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps

module tlbinv_top (
  input  wire logic                   i_mclk,
  input  wire logic                   i_resetn,
  input  wire tlbinv_pkg::tlbinv_bus_t  i_bus,
  input  wire tlbinv_pkg::tlbinv_cmd_t  i_cmd,
  input  wire tlbinv_pkg::tlbinv_fill_t i_fill,
  input  wire tlbinv_pkg::tlbinv_caps_t i_caps,
  output logic [31:0]                 o_rdata,
  output logic                        o_done,
  output logic                        o_illegal,
  output logic [tlbinv_pkg::NENT-1:0] o_entry_valid
);

  typedef struct packed {
    tlbinv_pkg::tlbinv_ent_t [tlbinv_pkg::NENT-1:0] ents;
    logic [2:0]  ctrl;
    logic [31:0] rdata;
    logic        done;
    logic        ill;
    logic [7:0]  err_cnt;
    logic [3:0]  err_op;
  } tlbinv_state_t;

  tlbinv_state_t st_reg;
  tlbinv_state_t st_next;

  ////////////////////////////////////////////////////////////////////
  // legality of a command
  function automatic logic cmd_legal(
    input tlbinv_pkg::tlbinv_cmd_t  c,
    input tlbinv_pkg::tlbinv_caps_t k
  );
    logic ok;
    logic onsec;
    ok    = 1'b0;
    onsec = (c.queue == tlbinv_pkg::TLBINV_Q_SEC);
    unique case (c.op)
      tlbinv_pkg::TLBINV_HYP_ALL,
      tlbinv_pkg::TLBINV_HYP_VA,
      tlbinv_pkg::TLBINV_HYP_VAA,
      tlbinv_pkg::TLBINV_HYP_ASID: begin
        ok = k.hyp; // R6
      end
      tlbinv_pkg::TLBINV_SEC_HYP_ALL,
      tlbinv_pkg::TLBINV_SEC_HYP_VA,
      tlbinv_pkg::TLBINV_SEC_HYP_VAA,
      tlbinv_pkg::TLBINV_SEC_HYP_ASID: begin
        ok = onsec && k.sec_hyp; // R12
      end
      tlbinv_pkg::TLBINV_S2_IPA,
      tlbinv_pkg::TLBINV_S12_VMID: begin
        ok = k.s2; // R14
      end
      tlbinv_pkg::TLBINV_SEC_S2_IPA,
      tlbinv_pkg::TLBINV_SEC_S12_VMID: begin
        ok = onsec && k.sec_s2; // R21
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    if (c.queue == 2'h3) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // does a legal command remove this entry
  function automatic logic ent_hit(
    input tlbinv_pkg::tlbinv_ent_t e,
    input tlbinv_pkg::tlbinv_cmd_t c,
    input logic [2:0]              ctl
  );
    logic                      r;
    logic                      host;
    logic                      wok;
    logic                      s1;
    logic                      vam;
    logic                      ipam;
    logic                      inrng;
    logic                      sec_op;
    tlbinv_pkg::tlbinv_world_t w;
    r      = 1'b0;
    sec_op = (c.op[3:2] == 2'h1) || (c.op == tlbinv_pkg::TLBINV_SEC_S2_IPA)
             || (c.op == tlbinv_pkg::TLBINV_SEC_S12_VMID);
    // ns and secure queues share the ns target
    if (sec_op) begin // R11
      w    = tlbinv_pkg::TLBINV_W_SEC;
      host = ctl[tlbinv_pkg::CTRL_SEC_HOST];
    end else if (c.queue == tlbinv_pkg::TLBINV_Q_REALM) begin // R8
      w    = tlbinv_pkg::TLBINV_W_REALM;
      host = ctl[tlbinv_pkg::CTRL_RLM_HOST];
    end else begin // R7
      w    = tlbinv_pkg::TLBINV_W_NS;
      host = ctl[tlbinv_pkg::CTRL_NS_HOST];
    end
    wok  = e.valid && (e.world == w);
    s1   = (e.stage == tlbinv_pkg::TLBINV_ST_S1);
    vam  = (e.page == c.addr[tlbinv_pkg::AW-1:tlbinv_pkg::PG_LSB])
           && (!c.leaf || e.leaf); // R2 R15
    inrng = (c.addr[tlbinv_pkg::AW-1:tlbinv_pkg::IN_ADDR_W] == '0); // R15
    ipam = vam && inrng && (e.vmid == c.vmid); // R13
    unique case (c.op)
      tlbinv_pkg::TLBINV_HYP_ALL,
      tlbinv_pkg::TLBINV_SEC_HYP_ALL: begin
        r = wok && s1 && (e.level != tlbinv_pkg::TLBINV_L_EL1); // R23
      end
      tlbinv_pkg::TLBINV_HYP_VA,
      tlbinv_pkg::TLBINV_SEC_HYP_VA: begin
        if (host) begin
          r = wok && s1 && vam && (e.level == tlbinv_pkg::TLBINV_L_HOST)
              && (e.glob || (e.asid == c.asid));
        end else begin
          r = wok && s1 && vam && (e.level == tlbinv_pkg::TLBINV_L_HYP);
        end
      end
      tlbinv_pkg::TLBINV_HYP_VAA,
      tlbinv_pkg::TLBINV_SEC_HYP_VAA: begin
        if (host) begin // R3
          r = wok && s1 && vam && (e.level == tlbinv_pkg::TLBINV_L_HOST); // R1
        end else begin // R4
          r = wok && s1 && vam && (e.level == tlbinv_pkg::TLBINV_L_HYP); // R1
        end
      end
      tlbinv_pkg::TLBINV_HYP_ASID,
      tlbinv_pkg::TLBINV_SEC_HYP_ASID: begin
        r = wok && s1 && (e.level == tlbinv_pkg::TLBINV_L_HOST)
            && !e.glob && (e.asid == c.asid); // R9 R10
      end
      tlbinv_pkg::TLBINV_S2_IPA: begin
        // only stage-two-only entries carry an ipa tag
        r = wok && (e.level == tlbinv_pkg::TLBINV_L_EL1)
            && (e.stage == tlbinv_pkg::TLBINV_ST_S2) && ipam; // R16 R17 R18
      end
      tlbinv_pkg::TLBINV_SEC_S2_IPA: begin
        r = wok && (e.level == tlbinv_pkg::TLBINV_L_EL1)
            && (e.stage == tlbinv_pkg::TLBINV_ST_S2) && ipam
            && (e.ipa_ns == c.ipa_space_select); // R20
      end
      tlbinv_pkg::TLBINV_S12_VMID,
      tlbinv_pkg::TLBINV_SEC_S12_VMID: begin
        r = wok && (e.level == tlbinv_pkg::TLBINV_L_EL1)
            && (e.vmid == c.vmid); // R19 R22
      end
      default: begin
        r = 1'b0;
      end
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic ok;
    logic [tlbinv_pkg::NENT-1:0] vld;
    ok      = 1'b0;
    vld     = '0;
    st_next = st_reg;
    st_next.done  = 1'b0;
    st_next.ill   = 1'b0;
    st_next.rdata = 32'h0000_0000;

    if (i_cmd.valid) begin
      ok = cmd_legal(i_cmd, i_caps);
      st_next.done = 1'b1;
      st_next.ill  = !ok;
      if (!ok) begin
        st_next.err_cnt = st_reg.err_cnt + 8'h01;
        st_next.err_op  = i_cmd.op;
      end
    end

    for (int i = 0; i < tlbinv_pkg::NENT; i++) begin
      if (ok && ent_hit(st_reg.ents[i], i_cmd, st_reg.ctrl)) begin // R24
        st_next.ents[i].valid = 1'b0;
      end
      if (i_fill.valid && (i_fill.idx == i[tlbinv_pkg::IDXW-1:0])) begin
        st_next.ents[i] = i_fill.ent;
      end
      vld[i] = st_reg.ents[i].valid;
    end

    if (i_bus.wr && (i_bus.addr == tlbinv_pkg::OFF_CTRL)) begin
      st_next.ctrl = i_bus.wdata[2:0];
    end
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        tlbinv_pkg::OFF_CTRL: begin
          st_next.rdata = {29'h0, st_reg.ctrl};
        end
        tlbinv_pkg::OFF_CAPS: begin
          st_next.rdata = {28'h000_0000, i_caps};
        end
        tlbinv_pkg::OFF_STAT: begin
          st_next.rdata = '0;
          st_next.rdata[tlbinv_pkg::STAT_VLD_LSB +: tlbinv_pkg::NENT] = vld;
          st_next.rdata[tlbinv_pkg::STAT_ERR_LSB +: 8] = st_reg.err_cnt;
          st_next.rdata[tlbinv_pkg::STAT_OP_LSB +: 4]  = st_reg.err_op;
        end
        default: begin
          st_next.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      st_reg      <= '0;
      st_reg.ctrl <= tlbinv_pkg::CTRL_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    o_rdata   = st_reg.rdata;
    o_done    = st_reg.done;
    o_illegal = st_reg.ill;
    for (int j = 0; j < tlbinv_pkg::NENT; j++) begin
      o_entry_valid[j] = st_reg.ents[j].valid;
    end
  end

endmodule // tlbinv_top

// >>> tlbinv_checker.sv
// Purpose: port checker for the tlb invalidation block
// Assumes: one clock, synchronous active-low reset
// Notes:   bound from the testbench top file
`timescale 1ns/1ps
module tlbinv_checker (
  input wire logic                     i_mclk,
  input wire logic                     i_resetn,
  input wire tlbinv_pkg::tlbinv_bus_t  i_bus,
  input wire tlbinv_pkg::tlbinv_cmd_t  i_cmd,
  input wire tlbinv_pkg::tlbinv_fill_t i_fill,
  input wire tlbinv_pkg::tlbinv_caps_t i_caps,
  input wire logic [31:0]              o_rdata,
  input wire logic                     o_done,
  input wire logic                     o_illegal,
  input wire logic [7:0]               o_entry_valid
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  wire       cv = i_cmd.valid;
  wire [3:0] op = i_cmd.op;
  wire       sq = i_cmd.queue == 2'h1;
  ////////////////////////////////////////////////////////////////////////////////
  a_done_pulse: assert property (cv |=> o_done) else $error("done missing");
  a_done_cause: assert property (!cv |=> !o_done) else $error("stray done");
  a_illegal_with_done: assert property (o_illegal |-> o_done) else $error("lone illegal");
  a_hyp_unsupported: assert property (
    cv && !i_caps.hyp && op < 4'h4 |=> o_illegal) else $error("hyp op accepted");
  a_sec_hyp_queue: assert property (
    cv && op[3:2] == 2'h1 && !sq |=> o_illegal) else $error("sec hyp op accepted");
  a_s2_unsupported: assert property (
    cv && !i_caps.s2 && op[3:1] == 3'h4 |=> o_illegal) else $error("s2 op accepted");
  a_sec_s2_queue: assert property (
    cv && op[3:1] == 3'h5 && !sq |=> o_illegal) else $error("sec s2 op accepted");
  a_sec_queue_legal: assert property (
    cv && sq && i_caps == 4'hf && op < 4'hc |=> !o_illegal) else $error("legal op refused");
  a_illegal_no_inv: assert property (
    o_illegal && !$past(i_fill.valid) |-> o_entry_valid == $past(o_entry_valid))
    else $error("illegal op changed entries");
  a_rdata_idle: assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0000_0000)
    else $error("read data outside read slot");
endmodule // tlbinv_checker

// >>> tlbinv_top_tb.sv
// Purpose: self-checking bench for the tlb invalidation block
// Assumes: one command at a time, answer one cycle later
// Notes:   entry table refilled before every legal command
`timescale 1ns/1ps
module tlbinv_top_tb;
  logic                     i_mclk = 1'b0;
  logic                     i_resetn = 1'b0;
  tlbinv_pkg::tlbinv_bus_t  i_bus = '0;
  tlbinv_pkg::tlbinv_cmd_t  i_cmd = '0;
  tlbinv_pkg::tlbinv_fill_t i_fill = '0;
  tlbinv_pkg::tlbinv_caps_t i_caps = 4'ha;
  logic [31:0]              o_rdata;
  logic                     o_done;
  logic                     o_illegal;
  logic [7:0]               o_entry_valid;
  tlbinv_pkg::tlbinv_ent_t  ents [8];
  int                       err_count = 0;
  int                       check_count = 0;
  int                       cyc = 0;

  always #2 i_mclk = ~i_mclk;

  tlbinv_top dut_u (.i_mclk, .i_resetn, .i_bus, .i_cmd, .i_fill, .i_caps,
                    .o_rdata, .o_done, .o_illegal, .o_entry_valid);
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk) i_bus <= {2'h2, a, d};
    @(posedge i_mclk) i_bus.wr <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_mclk) i_bus <= {2'h1, a, 32'h0000_0000};
    @(posedge i_mclk) i_bus.rd <= 1'b0;
    #1 chk("rdata", e, o_rdata);
  endtask

  // low address bits set on purpose: they must be ignored
  task cmd(input logic [3:0] op, input logic [1:0] q, input logic hi, lf, n, il,
           input logic [7:0] e, dc);
    @(posedge i_mclk) i_cmd <= {1'b1, op, q, 16'h0007, 16'h0003,
                               48'h0000_1234_5abc | {hi, 44'h0}, lf, n};
    @(posedge i_mclk) i_cmd.valid <= 1'b0;
    #1 chk("done", 1'b1, o_done);
    chk("illegal", il, o_illegal);
    chk("entries", e & ~dc, o_entry_valid & ~dc);
  endtask

  task fill_all;
    for (int i = 0; i < 8; i++) begin
      @(posedge i_mclk) i_fill <= {1'b1, i[2:0], ents[i]};
    end
    @(posedge i_mclk) i_fill.valid <= 1'b0;
  endtask

  task row(input logic [3:0] op, input logic [1:0] q, input logic [2:0] ctl,
           input logic hi, lf, n, input logic [7:0] e, dc);
    wr(8'h00, {29'h0, ctl});
    fill_all;
    cmd(op, q, hi, lf, n, 1'b0, e, dc);
  endtask

  function automatic tlbinv_pkg::tlbinv_ent_t ent(input logic [1:0] w, l, s,
                                                   input logic g, lf, n,
                                                   input logic [15:0] a, v);
    return {1'b1, w, l, s, g, lf, n, a, v, 36'h0_0001_2345};
  endfunction

  task finish_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      finish_test;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ents[0] = ent(2'h0, 2'h1, 2'h0, 1'b1, 1'b1, 1'b0, 16'h0005, 16'h0000);
    ents[1] = ent(2'h0, 2'h2, 2'h0, 1'b0, 1'b1, 1'b0, 16'h0007, 16'h0000);
    ents[2] = ent(2'h0, 2'h0, 2'h0, 1'b0, 1'b1, 1'b0, 16'h0007, 16'h0003);
    ents[3] = ent(2'h0, 2'h0, 2'h1, 1'b0, 1'b0, 1'b0, 16'h0000, 16'h0003);
    ents[4] = ent(2'h0, 2'h0, 2'h2, 1'b0, 1'b1, 1'b0, 16'h0007, 16'h0003);
    ents[5] = ent(2'h1, 2'h1, 2'h0, 1'b1, 1'b1, 1'b0, 16'h0000, 16'h0000);
    ents[6] = ent(2'h2, 2'h2, 2'h0, 1'b0, 1'b1, 1'b0, 16'h0007, 16'h0000);
    ents[7] = ent(2'h1, 2'h0, 2'h1, 1'b0, 1'b1, 1'b1, 16'h0000, 16'h0003);
    repeat (5) @(posedge i_mclk);
    i_resetn <= 1'b1;
    chk("entries", 32'h0000_0000, o_entry_valid);
    rd(8'h00, 32'h0000_0000);
    rd(8'h04, 32'h0000_000a);
    wr(8'h04, 32'h0000_0005);
    rd(8'h04, 32'h0000_000a);
    rd(8'h0c, 32'h0000_0000);
    wr(8'h00, 32'h0000_00ff);
    rd(8'h00, 32'h0000_0007);
    rd(8'h08, 32'h0000_0000);
    $display("register test done");
    @(posedge i_mclk) i_caps <= 4'h0;
    fill_all;
    for (int o = 0; o < 16; o++)
      for (int q = 0; q < 4; q++)
        cmd(o[3:0], q[1:0], 1'b0, 1'b0, 1'b0, 1'b1, 8'hff, 8'h00);
    @(posedge i_mclk) i_caps <= 4'hf;
    for (int q = 0; q < 4; q += 2)
      for (int o = 4; o < 12; o++)
        if (o < 8 || o > 9)
          cmd(o[3:0], q[1:0], 1'b0, 1'b0, 1'b0, 1'b1, 8'hff, 8'h00);
    rd(8'h08, 32'h000b_4cff);
    $display("illegal command test done");
    row(4'h2, 2'h0, 3'h0, 1'b0, 1'b0, 1'b0, 8'hfe, 8'h02);
    row(4'h2, 2'h1, 3'h0, 1'b0, 1'b0, 1'b0, 8'hfe, 8'h02);
    row(4'h2, 2'h0, 3'h1, 1'b0, 1'b0, 1'b0, 8'hfd, 8'h01);
    row(4'h2, 2'h2, 3'h4, 1'b0, 1'b0, 1'b0, 8'hbf, 8'h00);
    row(4'h3, 2'h0, 3'h1, 1'b0, 1'b0, 1'b0, 8'hfd, 8'h01);
    row(4'h3, 2'h2, 3'h4, 1'b0, 1'b0, 1'b0, 8'hbf, 8'h00);
    row(4'h0, 2'h0, 3'h0, 1'b0, 1'b0, 1'b0, 8'hfc, 8'h00);
    row(4'h4, 2'h1, 3'h2, 1'b0, 1'b0, 1'b0, 8'hdf, 8'h00);
    row(4'h8, 2'h0, 3'h0, 1'b0, 1'b0, 1'b0, 8'hf7, 8'h10);
    row(4'h8, 2'h0, 3'h0, 1'b0, 1'b1, 1'b0, 8'hff, 8'h10);
    row(4'h8, 2'h0, 3'h0, 1'b1, 1'b0, 1'b0, 8'hff, 8'h10);
    row(4'h9, 2'h0, 3'h0, 1'b0, 1'b0, 1'b0, 8'he3, 8'h00);
    row(4'h9, 2'h2, 3'h0, 1'b0, 1'b0, 1'b0, 8'hff, 8'h00);
    row(4'ha, 2'h1, 3'h0, 1'b0, 1'b0, 1'b1, 8'h7f, 8'h00);
    row(4'ha, 2'h1, 3'h0, 1'b0, 1'b0, 1'b0, 8'hff, 8'h00);
    row(4'hb, 2'h1, 3'h0, 1'b0, 1'b0, 1'b0, 8'h7f, 8'h00);
    row(4'h8, 2'h2, 3'h0, 1'b0, 1'b0, 1'b0, 8'hff, 8'h00);
    row(4'h1, 2'h0, 3'h0, 1'b0, 1'b1, 1'b0, 8'hfe, 8'h02);
    row(4'h1, 2'h0, 3'h1, 1'b0, 1'b1, 1'b0, 8'hfd, 8'h01);
    row(4'h6, 2'h1, 3'h0, 1'b0, 1'b0, 1'b0, 8'hdf, 8'h00);
    $display("invalidation scope test done");
    finish_test;
  end
endmodule // tlbinv_top_tb

bind tlbinv_top tlbinv_checker chk_u (.i_mclk, .i_resetn, .i_bus, .i_cmd, .i_fill,
                                      .i_caps, .o_rdata, .o_done, .o_illegal,
                                      .o_entry_valid);
